// >>> bench/mmap_core_bench.sv
// Self-checking bench for the memory map core
`timescale 1ns/1ps
`default_nettype none
module mmap_core_bench;
    import mmap_pkg::*;
    localparam int RAMB = 2048;
    localparam int FLB  = 32768;
    logic        clk = 1'b0, rst_n = 1'b0, mode_pin = 1'b1;
    logic [7:0]  avs_addr = 8'h0;
    logic        avs_rd = 1'b0, avs_wr = 1'b0, avs_wait;
    logic [31:0] avs_wdata = 32'h0, avs_rdata;
    logic        dbg_act = 1'b0, dbg_pen = 1'b0, hw_cmd = 1'b0, dbg_cyc = 1'b0;
    logic        pg_wr = 1'b0, fw_cmd = 1'b0, cpu_gnt, dbg_gnt, tgt_valid, tgt_done, ill;
    logic [3:0]  pg_wdata = 4'h0, pg_rdata;
    mmap_req_s   cpu_req = '0, dbg_req = '0;
    logic [15:0] cpu_rd, dbg_rd, tgt_rdata;
    mmap_tgt_e   tgt_sel;
    logic [17:0] tgt_addr;
    logic [1:0]  lag = 2'h0;
    int          errors = 0, checks = 0, ills = 0, seed = 32'hd66b;

    always #10 clk = ~clk;
    always @(posedge clk) if (ill === 1'b1) ills++;

    mmap_core #(.RAM_BYTES(RAMB), .FLASH_BYTES(FLB)) i_mmap_core (
        .CORE_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(avs_addr), .AVS_READ(avs_rd),
        .AVS_WRITE(avs_wr), .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA(avs_wdata),
        .AVS_READDATA(avs_rdata), .AVS_WAITREQUEST(avs_wait), .MODE_PIN(mode_pin),
        .DBG_ACTIVE(dbg_act), .DBG_PAGE_EN(dbg_pen), .CPU_FW_CMD(fw_cmd), .DBG_HW_CMD(hw_cmd),
        .CPU_PAGE_WR(pg_wr), .CPU_PAGE_WDATA(pg_wdata), .CPU_PAGE_RDATA(pg_rdata),
        .CPU_REQ(cpu_req), .CPU_GRANT(cpu_gnt), .CPU_RDATA(cpu_rd), .DBG_REQ(dbg_req),
        .DBG_CYCLE(dbg_cyc), .DBG_GRANT(dbg_gnt), .DBG_RDATA(dbg_rd), .TGT_VALID(tgt_valid),
        .TGT_SEL(tgt_sel), .TGT_ADDR(tgt_addr), .TGT_WR(), .TGT_WDATA(),
        .TGT_RDATA(tgt_rdata), .TGT_DONE(tgt_done), .ILLEGAL_RESET(ill),
        .SPECIAL_MODE(), .EXT_BUS_EN(), .IRQ()
    );
    mmap_target_model i_mmap_target_model (
        .clk(clk), .rst_n(rst_n), .valid(tgt_valid), .addr(tgt_addr), .lag(lag),
        .rdata(tgt_rdata), .done(tgt_done)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_addr  <= a;
        avs_wdata <= d;
        avs_wr    <= w;
        avs_rd    <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_wait !== 1'b0 && n < 50);
        q = avs_rdata;
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "register bus hang");
    endtask

    task automatic xfer(input logic d, input logic [15:0] a, input logic wd,
                        output logic [21:0] seen, output logic [15:0] r, output int n);
        mmap_req_s q;
        q = '{req:1'b1, wr:1'b0, word:wd, addr:a, wdata:16'h0};
        seen = '0;
        n = 0;
        @(posedge clk);
        lag <= 2'($random(seed));
        if (d) dbg_req <= q;
        else cpu_req <= q;
        do begin
            @(posedge clk);
            n++;
            if (tgt_valid === 1'b1) seen = {1'b1, tgt_sel, tgt_addr};
        end while ((d ? dbg_gnt : cpu_gnt) !== 1'b1 && n < 400);
        if (d) dbg_req.req <= 1'b0;
        else cpu_req.req <= 1'b0;
        @(posedge clk);
        r = d ? dbg_rd : cpu_rd;
    endtask

    function automatic logic [20:0] cmap(input logic [15:0] a, input logic [3:0] pg,
                                         input logic vis);
        logic [17:0] g;
        int          x;
        g = {(a[15:14] == 2'h3) ? 4'hf : pg, a[13:0]};
        x = int'(g);
        if (x <= 32'h3ff) return {MMAP_TGT_REG, g};
        if (x <= 32'h47f) return vis ? {MMAP_TGT_INFO, g} : {MMAP_TGT_NONE, 18'h0};
        if (x <= 32'h7ff) return {MMAP_TGT_NONE, 18'h0};
        if (x <= 32'h7ff + RAMB) return {MMAP_TGT_RAM, g};
        if (x >= 32'h40000 - FLB) return {MMAP_TGT_FLASH, g};
        return {MMAP_TGT_NONE, 18'h0};
    endfunction

    task automatic probe(input logic d, input logic [15:0] a, input logic wd,
                         input logic [20:0] e);
        logic [21:0] seen;
        logic [15:0] r, x;
        logic        hit;
        int          n, c;
        c = ills;
        hit = (e[20:18] != MMAP_TGT_NONE);
        x = e[15:0] ^ 16'h5a5a;
        xfer(d, a, wd, seen, r, n);
        repeat (3) @(posedge clk);
        chk(seen, hit ? {1'b1, e} : 22'h0, "route");
        if (hit) chk(wd ? r : {8'h0, r[7:0]}, wd ? x : {8'h0, x[15:8]}, "rdata");
        chk(ills - c, (!d && !hit && !fw_cmd) ? 1 : 0, "illegal reset");
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole run is under a thousand cycles; this leaves wide margin
    initial begin
        #800000;
        errors++;
        wrap_up();
    end

    initial begin
        static logic [7:0]  offs [5] = '{8'h30, 8'h32, 8'h33, 8'h34, 8'h40};
        static logic [31:0] rstv [5] = '{32'hfe, 32'h80, 32'h0, 32'h0, 32'h0};
        static logic [13:0] lo [4] = '{14'h0100, 14'h0410, 14'h0600, 14'h0900};
        static logic [2:0]  dctl [5] = '{3'h4, 3'h4, 3'h0, 3'h3, 3'h0};
        static logic [15:0] dadr [5] = '{16'hff10, 16'hbf20, 16'hff10, 16'h8010, 16'h8010};
        logic [20:0] dexp [5];
        logic [31:0] q, v;
        logic [3:0]  pg;
        logic [15:0] a, r;
        logic [21:0] seen;
        int          i, n;
        dexp = '{{MMAP_TGT_DBG, 18'h3ff10}, {MMAP_TGT_DBG, 18'h3ff20},
                 {MMAP_TGT_FLASH, 18'h3ff10}, {MMAP_TGT_FLASH, 18'h38010},
                 {MMAP_TGT_FLASH, 18'h3c010}};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            avs(1'b0, offs[i], 32'h0, q);
            chk(q, rstv[i], "reset value");
        end
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            avs(1'b1, 8'h33, v, q);
            avs(1'b1, 8'h40, $random(seed), q);
            avs(1'b0, 8'h33, 32'h0, q);
            chk(q, {31'h0, v[0]}, "visibility");
            avs(1'b0, 8'h40, 32'h0, q);
            chk(q, 32'h0, "unmapped read");
        end
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            pg = 4'($random(seed));
            @(posedge clk);
            pg_wr    <= 1'b1;
            pg_wdata <= pg;
            @(posedge clk);
            pg_wr <= 1'b0;
            @(posedge clk);
            chk(pg_rdata, pg, "call page");
            avs(1'b0, 8'h30, 32'h0, q);
            chk(q, {24'h0, 4'hf, pg}, "page read");
        end
        $display("test call page done");
        for (i = 0; i < 24; i++) begin
            pg = (i < 8) ? 4'h0 : 4'(i - 8);
            a = {(i >= 20) ? 2'h3 : 2'h2, (i < 8) ? lo[i / 2] : 14'($random(seed))};
            a[0] = 1'b0;
            avs(1'b1, 8'h30, {28'h0, pg}, q);
            avs(1'b1, 8'h33, {31'h0, i[0]}, q);
            probe(1'b0, a, i[2], cmap(a, pg, i[0]));
        end
        avs(1'b1, 8'h30, 32'h1, q);
        fw_cmd <= 1'b1;
        probe(1'b0, 16'h8000, 1'b1, {MMAP_TGT_NONE, 18'h0});
        fw_cmd <= 1'b0;
        $display("test cpu map done");
        avs(1'b1, 8'h30, 32'hf, q);
        avs(1'b1, 8'h34, 32'he, q);
        dbg_act <= 1'b1;
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            {dbg_cyc, dbg_pen, hw_cmd} <= dctl[i];
            probe(1'b1, dadr[i], 1'b1, dexp[i]);
        end
        avs(1'b1, 8'h34, 32'h1, q);
        {dbg_cyc, dbg_pen, hw_cmd} <= 3'h3;
        probe(1'b1, 16'h8000, 1'b1, {MMAP_TGT_NONE, 18'h0});
        dbg_act <= 1'b0;
        $display("test debug map done");
        cpu_req <= '{req:1'b1, wr:1'b0, word:1'b1, addr:16'hc100, wdata:16'h0};
        xfer(1'b1, 16'hc200, 1'b1, seen, r, n);
        chk(n > 128 && n <= 160, 1'b1, "debug wait");
        n = 0;
        while (cpu_gnt !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        cpu_req.req <= 1'b0;
        $display("test arbitration done");
        mode_pin <= 1'b0;
        rst_n    <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        avs(1'b0, 8'h32, 32'h0, q);
        chk(q, 32'h0, "mode latch");
        avs(1'b0, 8'h30, 32'h0, q);
        chk(q, 32'hfe, "page after reset");
        $display("test reset done");
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> bench/mmap_core_properties.sv
// Port checks for the memory map core
`timescale 1ns/1ps
`default_nettype none
module mmap_core_properties
    import mmap_pkg::*;
(
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    // Buses
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    input wire mmap_req_s   CPU_REQ,
    input wire logic        CPU_GRANT,
    input wire logic        CPU_FW_CMD,
    input wire mmap_req_s   DBG_REQ,
    input wire logic        DBG_GRANT,
    input wire logic        DBG_ACTIVE,
    input wire logic        TGT_VALID,
    input wire logic [17:0] TGT_ADDR,
    // System
    input wire logic        ILLEGAL_RESET,
    input wire logic        EXT_BUS_EN,
    input wire logic        IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    // Saturating so a stuck debug request cannot wrap past the bound
    logic [8:0] stall_ff;
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stall_ff <= 9'h0;
        end else if (DBG_GRANT || !DBG_REQ.req) begin
            stall_ff <= 9'h0;
        end else if (stall_ff != 9'h1ff) begin
            stall_ff <= stall_ff + 9'h1;
        end
    end

    sequence s_avs_pend;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_cpu_unimp;
        CPU_GRANT && !TGT_VALID && !CPU_FW_CMD;
    endsequence
    sequence s_cpu_solo;
        TGT_VALID && CPU_REQ.req && !DBG_REQ.req && !DBG_ACTIVE;
    endsequence

    property p_avs_one_wait;
        s_avs_pend |=> !AVS_WAITREQUEST;
    endproperty
    property p_ill_fire;
        s_cpu_unimp |=> ILLEGAL_RESET;
    endproperty
    property p_ill_cause;
        ILLEGAL_RESET |-> $past(CPU_GRANT) && !$past(DBG_GRANT);
    endproperty
    property p_no_irq;
        IRQ == 1'b0;
    endproperty
    property p_no_ext;
        EXT_BUS_EN == 1'b0;
    endproperty
    property p_one_master;
        !(CPU_GRANT && DBG_GRANT);
    endproperty
    property p_dbg_stall;
        stall_ff <= 9'ha0;
    endproperty
    property p_cpu_served;
        $rose(CPU_REQ.req) |-> ##[1:200] CPU_GRANT;
    endproperty
    property p_low_bits;
        s_cpu_solo |-> TGT_ADDR[13:0] == CPU_REQ.addr[13:0];
    endproperty
    property p_top_fixed;
        s_cpu_solo and CPU_REQ.addr[15:14] == 2'h3 |-> TGT_ADDR[17:14] == 4'hf;
    endproperty

    a_avs_one_wait: assert property (p_avs_one_wait) else $error("waitrequest too long");
    a_ill_fire: assert property (p_ill_fire) else $error("illegal reset missing");
    a_ill_cause: assert property (p_ill_cause) else $error("illegal reset stray");
    a_no_irq: assert property (p_no_irq) else $error("interrupt raised");
    a_no_ext: assert property (p_no_ext) else $error("external bus on");
    a_one_master: assert property (p_one_master) else $error("two grants");
    a_dbg_stall: assert property (p_dbg_stall) else $error("debug starved");
    a_cpu_served: assert property (p_cpu_served) else $error("cpu never served");
    a_low_bits: assert property (p_low_bits) else $error("offset bits wrong");
    a_top_fixed: assert property (p_top_fixed) else $error("top block paged");
endmodule

bind mmap_core mmap_core_properties i_mmap_core_properties (
    .CORE_CLK, .RESET_N, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .CPU_REQ,
    .CPU_GRANT, .CPU_FW_CMD, .DBG_REQ, .DBG_GRANT, .DBG_ACTIVE, .TGT_VALID,
    .TGT_ADDR, .ILLEGAL_RESET, .EXT_BUS_EN, .IRQ
);
`default_nettype wire

// >>> bench/mmap_target_model.sv
// Target bus responder with a programmable answer lag
`timescale 1ns/1ps
`default_nettype none
module mmap_target_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Target bus
    input  wire logic        valid,
    input  wire logic [17:0] addr,
    input  wire logic [1:0]  lag,
    output logic [15:0]      rdata,
    output logic             done
);
    logic [1:0] cnt_ff;

    // Data toggles outside the answer cycle so a late capture shows up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
            done   <= 1'b0;
            rdata  <= 16'h0;
        end else if (valid && !done && cnt_ff == lag) begin
            cnt_ff <= 2'h0;
            done   <= 1'b1;
            rdata  <= addr[15:0] ^ 16'h5a5a;
        end else begin
            cnt_ff <= (valid && !done) ? cnt_ff + 2'h1 : 2'h0;
            done   <= 1'b0;
            rdata  <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/mmap_core.sv
// Memory map control: registers, decode, arbitration and routing
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mmap_core
    import mmap_pkg::*;
#(
    parameter int RAM_BYTES   = 2048,
    parameter int FLASH_BYTES = 32768
) (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    // Avalon-MM register slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Mode pin and debug state
    input  wire logic        MODE_PIN,
    input  wire logic        DBG_ACTIVE,
    input  wire logic        DBG_PAGE_EN,
    input  wire logic        CPU_FW_CMD,
    input  wire logic        DBG_HW_CMD,
    // Paged call/return special page access
    input  wire logic        CPU_PAGE_WR,
    input  wire logic [3:0]  CPU_PAGE_WDATA,
    output logic [3:0]       CPU_PAGE_RDATA,
    // CPU master
    input  wire mmap_req_s   CPU_REQ,
    output logic             CPU_GRANT,
    output logic [15:0]      CPU_RDATA,
    // Debug master
    input  wire mmap_req_s   DBG_REQ,
    input  wire logic        DBG_CYCLE,
    output logic             DBG_GRANT,
    output logic [15:0]      DBG_RDATA,
    // Target bus
    output logic             TGT_VALID,
    output mmap_tgt_e        TGT_SEL,
    output logic [17:0]      TGT_ADDR,
    output logic             TGT_WR,
    output logic [15:0]      TGT_WDATA,
    input  wire logic [15:0] TGT_RDATA,
    input  wire logic        TGT_DONE,
    // System
    output logic             ILLEGAL_RESET,
    output logic             SPECIAL_MODE,
    output logic             EXT_BUS_EN,
    output logic             IRQ
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  visctl_ff;
    logic [3:0]  page_ff;
    logic [3:0]  dbg_page_ff;
    logic        mode_ff;
    logic        rst_seen_ff;
    logic [7:0]  wait_ff;
    logic        dbg_prio_ff;
    logic        owner_dbg_ff;
    logic        busy_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        illegal_ff;
    logic        byte_hi_ff;
    logic [15:0] cpu_rdata_ff;
    logic [15:0] dbg_rdata_ff;

    mmap_dec_s   cpu_dec;
    mmap_dec_s   dbg_dec;
    logic [3:0]  dbg_idx;
    logic        dbg_use_own;
    logic        pick_dbg;
    logic        start;
    mmap_dec_s   sel_dec;
    mmap_req_s   sel_req;
    logic [31:0] nxt_rdata;
    logic        wr_lo_ok;
    logic        acc;

    // ----------------------------------------
    // Decoders
    // ----------------------------------------
    mmap_decode #(
        .RAM_BYTES   (RAM_BYTES),
        .FLASH_BYTES (FLASH_BYTES)
    ) u_cpu_dec (
        .local_addr (CPU_REQ.addr),
        .req        (CPU_REQ.req),
        .page_idx   (page_ff),
        .dbg_active (DBG_ACTIVE),
        .dbg_cycle  (1'b0),
        .info_vis   (visctl_ff[MMAP_VIS_BIT]),
        .dec        (cpu_dec)
    );

    // Debug page index only for enabled firmware or hardware commands
    assign dbg_use_own = DBG_PAGE_EN && (CPU_FW_CMD || DBG_HW_CMD);
    assign dbg_idx     = dbg_use_own ? dbg_page_ff : page_ff;

    mmap_decode #(
        .RAM_BYTES   (RAM_BYTES),
        .FLASH_BYTES (FLASH_BYTES)
    ) u_dbg_dec (
        .local_addr (DBG_REQ.addr),
        .req        (DBG_REQ.req),
        .page_idx   (dbg_idx),
        .dbg_active (DBG_ACTIVE),
        .dbg_cycle  (DBG_CYCLE),
        .info_vis   (visctl_ff[MMAP_VIS_BIT]),
        .dec        (dbg_dec)
    );

    // ----------------------------------------
    // Operating mode
    // ----------------------------------------
    // Pin is sampled at the first edge after release, never in reset
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_ff     <= 1'b0;
            rst_seen_ff <= 1'b0;
        end else if (!rst_seen_ff) begin
            mode_ff     <= MODE_PIN;
            rst_seen_ff <= 1'b1;
        end
    end

    assign SPECIAL_MODE = rst_seen_ff ? mode_ff : MODE_PIN;
    assign EXT_BUS_EN   = 1'b0;
    assign IRQ          = 1'b0;

    // ----------------------------------------
    // Avalon-MM slave: one wait cycle, then acknowledge
    // ----------------------------------------
    assign acc             = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = acc && !ack_ff;
    // Write lands only at the edge that ends the acknowledge cycle
    assign wr_lo_ok        = AVS_WRITE && ack_ff && AVS_BYTEENABLE[0];

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc && !ack_ff;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0;
        case (AVS_ADDRESS)
            MMAP_OFS_PAGE:    nxt_rdata = {24'h0, MMAP_PAGE_HI_NIB, page_ff};
            MMAP_OFS_MODE:    nxt_rdata = {24'h0, SPECIAL_MODE, 7'h0};
            MMAP_OFS_VISCTL:  nxt_rdata = {24'h0, visctl_ff};
            MMAP_OFS_DBGPAGE: nxt_rdata = {28'h0, dbg_page_ff};
            MMAP_OFS_STATUS:  nxt_rdata = {29'h0, dbg_prio_ff, owner_dbg_ff, busy_ff};
            default:          nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_ff <= 32'h0;
        end else if (AVS_READ && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign AVS_READDATA = rdata_ff;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            visctl_ff <= MMAP_VISCTL_RST;
        end else if (wr_lo_ok && AVS_ADDRESS == MMAP_OFS_VISCTL) begin
            visctl_ff <= {7'h0, AVS_WRITEDATA[MMAP_VIS_BIT]};
        end
    end

    // Special call/return access wins over a bus write in the same cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            page_ff <= MMAP_PAGE_RST;
        end else if (CPU_PAGE_WR) begin
            page_ff <= CPU_PAGE_WDATA;
        end else if (wr_lo_ok && AVS_ADDRESS == MMAP_OFS_PAGE) begin
            page_ff <= AVS_WRITEDATA[3:0];
        end
    end

    assign CPU_PAGE_RDATA = page_ff;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dbg_page_ff <= MMAP_DBGPAGE_RST;
        end else if (wr_lo_ok && AVS_ADDRESS == MMAP_OFS_DBGPAGE) begin
            dbg_page_ff <= AVS_WRITEDATA[3:0];
        end
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    // Debug stall counter; wait_ff saturates past the limit
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_ff     <= 8'h0;
            dbg_prio_ff <= 1'b0;
        end else if (!DBG_REQ.req || (start && pick_dbg)) begin
            wait_ff     <= 8'h0;
            dbg_prio_ff <= 1'b0;
        end else begin
            if (wait_ff != 8'hff) begin
                wait_ff <= wait_ff + 8'h1;
            end
            if (wait_ff >= 8'(MMAP_DBG_WAIT_MAX)) begin
                dbg_prio_ff <= 1'b1;
            end
        end
    end

    // A transfer in flight finishes first, so the CPU stalls after its operation
    assign pick_dbg = DBG_REQ.req && (!CPU_REQ.req || dbg_prio_ff);
    assign start    = !busy_ff && (CPU_REQ.req || DBG_REQ.req);
    assign sel_req  = owner_dbg_ff ? DBG_REQ : CPU_REQ;
    assign sel_dec  = owner_dbg_ff ? dbg_dec : cpu_dec;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_ff      <= 1'b0;
            owner_dbg_ff <= 1'b0;
        end else if (start) begin
            busy_ff      <= 1'b1;
            owner_dbg_ff <= pick_dbg;
        end else if (busy_ff && (TGT_DONE || sel_dec.tgt == MMAP_TGT_NONE)) begin
            busy_ff <= 1'b0;
        end
    end

    // Unimplemented targets are never put on the bus; debug gets a dummy end
    assign TGT_VALID = busy_ff && sel_dec.tgt != MMAP_TGT_NONE;
    assign TGT_SEL   = sel_dec.tgt;
    assign TGT_ADDR  = sel_dec.gaddr;
    assign TGT_WR    = sel_req.wr;
    assign TGT_WDATA = sel_req.wdata;
    assign CPU_GRANT = busy_ff && !owner_dbg_ff &&
                       (TGT_DONE || sel_dec.tgt == MMAP_TGT_NONE);
    assign DBG_GRANT = busy_ff && owner_dbg_ff &&
                       (TGT_DONE || sel_dec.tgt == MMAP_TGT_NONE);

    // ----------------------------------------
    // Read data and byte swapping
    // ----------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            byte_hi_ff <= 1'b0;
        end else if (start) begin
            byte_hi_ff <= !pick_dbg && !CPU_REQ.word && !CPU_REQ.addr[0];
        end
    end

    // Even byte reads arrive on the high lane; CPU expects low lane
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cpu_rdata_ff <= 16'h0;
            dbg_rdata_ff <= 16'h0;
        end else if (busy_ff && TGT_DONE) begin
            if (owner_dbg_ff) begin
                dbg_rdata_ff <= TGT_RDATA;
            end else if (byte_hi_ff) begin
                cpu_rdata_ff <= {8'h0, TGT_RDATA[15:8]};
            end else begin
                cpu_rdata_ff <= TGT_RDATA;
            end
        end
    end

    assign CPU_RDATA = cpu_rdata_ff;
    assign DBG_RDATA = dbg_rdata_ff;

    // ----------------------------------------
    // Illegal access reset
    // ----------------------------------------
    // Firmware commands and the debug master are exempt
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= busy_ff && !owner_dbg_ff && !CPU_FW_CMD &&
                          sel_dec.tgt == MMAP_TGT_NONE;
        end
    end

    assign ILLEGAL_RESET = illegal_ff;
endmodule
`default_nettype wire

// >>> hdl/mmap_decode.sv
// Local to global address translation and region decode
`timescale 1ns/1ps
`default_nettype none
module mmap_decode
    import mmap_pkg::*;
#(
    parameter int RAM_BYTES   = 2048,
    parameter int FLASH_BYTES = 32768
) (
    // Access
    input  wire logic [15:0] local_addr,
    input  wire logic        req,
    input  wire logic [3:0]  page_idx,
    input  wire logic        dbg_active,
    input  wire logic        dbg_cycle,
    input  wire logic        info_vis,
    // Result
    output mmap_dec_s        dec
);
    localparam logic [17:0] RAM_HI   = MMAP_UNIMP_HI + 18'(RAM_BYTES);
    localparam logic [17:0] FLASH_LO = 18'(MMAP_FLASH_END - 19'(FLASH_BYTES));

    logic [3:0]  page;
    logic [17:0] ga;
    logic        dbg_hit;

    always_comb begin
        case (local_addr[15:14])
            2'h0:    page = MMAP_PAGE_FIX0;
            2'h1:    page = MMAP_PAGE_FIX1;
            2'h2:    page = page_idx;
            default: page = MMAP_PAGE_TOP;
        endcase
    end

    // Page placed above the low fourteen bits
    assign ga = {page, local_addr[13:0]};

    // Debug resources overlay only on debug cycles while active
    always_comb begin
        dbg_hit = 1'b0;
        if (dbg_active && dbg_cycle) begin
            if (local_addr[15:8] == MMAP_DBG_LOC_HI) begin
                dbg_hit = 1'b1;
            end else if (local_addr[15:8] == MMAP_DBG_ALT_HI &&
                         page_idx == MMAP_PAGE_HI_NIB) begin
                dbg_hit = 1'b1;
            end
        end
    end

    always_comb begin
        dec.valid = req;
        dec.gaddr = ga;
        if (dbg_hit) begin
            dec.tgt = MMAP_TGT_DBG;
        end else if (ga <= MMAP_REG_TOP) begin
            dec.tgt = MMAP_TGT_REG;
        end else if (ga >= MMAP_INFO_LO && ga <= MMAP_INFO_HI) begin
            dec.tgt = info_vis ? MMAP_TGT_INFO : MMAP_TGT_NONE;
        end else if (ga <= MMAP_UNIMP_HI) begin
            dec.tgt = MMAP_TGT_NONE;
        end else if (ga >= MMAP_RAM_LO && ga <= RAM_HI) begin
            dec.tgt = MMAP_TGT_RAM;
        end else if (ga >= FLASH_LO && ga <= MMAP_FLASH_TOP) begin
            dec.tgt = MMAP_TGT_FLASH;
        end else begin
            dec.tgt = MMAP_TGT_NONE;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/mmap_pkg.sv
// Package for the memory map control and arbiter block
package mmap_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0]  MMAP_OFS_PAGE     = 8'h30;
    localparam logic [7:0]  MMAP_OFS_MODE     = 8'h32;
    localparam logic [7:0]  MMAP_OFS_VISCTL   = 8'h33;
    localparam logic [7:0]  MMAP_OFS_DBGPAGE  = 8'h34;
    localparam logic [7:0]  MMAP_OFS_STATUS   = 8'h38;
    localparam logic [7:0]  MMAP_VISCTL_RST   = 8'h00;
    localparam logic [3:0]  MMAP_PAGE_RST     = 4'he;
    localparam logic [3:0]  MMAP_DBGPAGE_RST  = 4'h0;
    localparam int          MMAP_VIS_BIT      = 0;
    // ----------------------------------------
    // Global map
    // ----------------------------------------
    localparam logic [17:0] MMAP_REG_TOP      = 18'h003ff;
    localparam logic [17:0] MMAP_INFO_LO      = 18'h00400;
    localparam logic [17:0] MMAP_INFO_HI      = 18'h0047f;
    localparam logic [17:0] MMAP_UNIMP_HI     = 18'h007ff;
    localparam logic [17:0] MMAP_RAM_LO       = 18'h00800;
    localparam logic [18:0] MMAP_FLASH_END    = 19'h40000;
    localparam logic [17:0] MMAP_FLASH_TOP    = 18'h3ffff;
    localparam logic [17:0] MMAP_DBG_GLO_LO   = 18'h3ff00;
    // ----------------------------------------
    // Local map
    // ----------------------------------------
    localparam logic [1:0]  MMAP_BLK_WINDOW   = 2'h2;
    localparam logic [3:0]  MMAP_PAGE_FIX0    = 4'hc;
    localparam logic [3:0]  MMAP_PAGE_FIX1    = 4'hd;
    localparam logic [3:0]  MMAP_PAGE_TOP     = 4'hf;
    localparam logic [7:0]  MMAP_DBG_LOC_HI   = 8'hff;
    localparam logic [7:0]  MMAP_DBG_ALT_HI   = 8'hbf;
    localparam logic [3:0]  MMAP_PAGE_HI_NIB  = 4'hf;
    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    localparam int          MMAP_DBG_WAIT_MAX = 128;

    typedef enum logic [2:0] {
        MMAP_TGT_REG,
        MMAP_TGT_INFO,
        MMAP_TGT_RAM,
        MMAP_TGT_FLASH,
        MMAP_TGT_DBG,
        MMAP_TGT_NONE
    } mmap_tgt_e;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmap_req_s;

    typedef struct packed {
        logic        valid;
        mmap_tgt_e   tgt;
        logic [17:0] gaddr;
    } mmap_dec_s;
endpackage
